// *** dv/dibc_ctrl_model.sv ***
// memory controller model that drives the command pins of the tracker
// assumes the bench calls its tasks; pins change on the falling link edge
`timescale 1ns/1ps
module dibc_ctrl_model (
   // link clock
   input wire logic linkClk,
   // command pins
   output logic clkEnable,
   output logic chipSelN,
   output logic rowStrobeN,
   output logic colStrobeN,
   output logic writeEnN,
   output logic [1:0] bankAddr,
   output logic autoPre
);
   logic [2:0] junk;
   initial begin
      clkEnable = 1'b1;
      chipSelN = 1'b1;
      {rowStrobeN, colStrobeN, writeEnN} = 3'h7;
      bankAddr = 2'h0;
      autoPre = 1'b0;
      junk = 3'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   // deselected strobes keep moving so a stale command is never re-decoded
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge linkClk);
         junk = junk + 3'h1;
         chipSelN = 1'b1;
         {rowStrobeN, colStrobeN, writeEnN} = junk;
         bankAddr = junk[1:0];
         autoPre = junk[0];
      end
   endtask
   task automatic set_enable(input logic en);
      @(negedge linkClk);
      clkEnable = en;
   endtask
   // one command for one link cycle; the caller releases it with idle
   task automatic issue(input dibc_pkg::dibc_cmd_t c, input logic [1:0] b,
                        input logic ap);
      @(negedge linkClk);
      chipSelN = 1'b0;
      rowStrobeN = !(c inside {dibc_pkg::CMD_ACT, dibc_pkg::CMD_PRE,
                               dibc_pkg::CMD_REF, dibc_pkg::CMD_MRS});
      colStrobeN = !(c inside {dibc_pkg::CMD_RD, dibc_pkg::CMD_WR,
                               dibc_pkg::CMD_REF, dibc_pkg::CMD_MRS});
      writeEnN = !(c inside {dibc_pkg::CMD_WR, dibc_pkg::CMD_PRE,
                             dibc_pkg::CMD_MRS, dibc_pkg::CMD_BST});
      bankAddr = b;
      autoPre = ap;
   endtask
endmodule

// *** dv/dibc_tracker_tb.sv ***
// self-checking bench of the inter-bank command tracker
// assumes the controller model drives the pins; exit and refresh counts shortened, row and precharge counts lengthened by params
`timescale 1ns/1ps
module dibc_tracker_tb;
   localparam int XSR = 4;
   localparam int RCD = 8;
   localparam int RP = 8;
   localparam int RFC = 8;
   localparam int HB = dibc_pkg::BURST_LEN / 2;
   localparam int CL = dibc_pkg::CAS_LAT_UP;
   localparam int WTR = dibc_pkg::WTR_CK;
   typedef struct {
      dibc_pkg::dibc_cmd_t c1;
      logic a1;
      dibc_pkg::dibc_cmd_t c2;
      logic [1:0] b2;
      int gap;
      logic viol;
   } dibc_case_t;
   logic clock = 1'b0;
   logic linkClk = 1'b0;
   logic rst = 1'b1;
   logic [dibc_pkg::NUM_BANKS*dibc_pkg::ST_W-1:0] bankState_ff;
   logic violation_ff;
   logic update_ff;
   logic clkEnable;
   logic chipSelN;
   logic rowStrobeN;
   logic colStrobeN;
   logic writeEnN;
   logic [1:0] bankAddr;
   logic autoPre;
   int mismatches = 0;
   int num_checks = 0;
   dibc_case_t cases [15];
   ////////////////////////////////////////////////////////////////////////
   always #2.5 clock = ~clock;
   // link clock runs free, phase unrelated to the core clock
   initial begin
      #13.7;
      forever #40 linkClk = ~linkClk;
   end
   dibc_tracker #(.RCD_CK(RCD), .RP_CK(RP), .RFC_CK(RFC), .XSR_CK(XSR)) u_dut (
      .clock(clock), .rst(rst), .bankState_ff(bankState_ff),
      .violation_ff(violation_ff), .update_ff(update_ff), .linkClk(linkClk),
      .clkEnable(clkEnable), .chipSelN(chipSelN), .rowStrobeN(rowStrobeN),
      .colStrobeN(colStrobeN), .writeEnN(writeEnN), .bankAddr(bankAddr),
      .autoPre(autoPre));
   dibc_ctrl_model u_ctrl (
      .linkClk(linkClk), .clkEnable(clkEnable), .chipSelN(chipSelN),
      .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnN(writeEnN),
      .bankAddr(bankAddr), .autoPre(autoPre));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [11:0] seen,
                        input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   function automatic logic [2:0] st(input int b);
      return bankState_ff[b*3 +: 3];
   endfunction
   // reset spans three rising link edges; the exit delay reloads once enable is seen
   task automatic do_reset();
      @(negedge clock);
      rst = 1'b1;
      repeat (40) @(negedge clock);
      rst = 1'b0;
      u_ctrl.idle(XSR + 6);
   endtask
   // snapshots are samples, so poll each link cycle with a bound
   task automatic wait_state(input string what, input int b,
                             input logic [2:0] exp);
      logic found;
      found = 1'b0;
      for (int i = 0; i < 60 && !found; i++) begin
         u_ctrl.idle(1);
         found = (st(b) === exp);
      end
      check(what, found, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      repeat (40) @(negedge clock);
      check("state in reset", bankState_ff, 12'h000);
      check("violation in reset", violation_ff, 1'b0);
      check("update in reset", update_ff, 1'b0);
      rst = 1'b0;
      u_ctrl.idle(XSR + 6);
   endtask
   task automatic t_enable_gate();
      u_ctrl.set_enable(1'b0);
      u_ctrl.idle(2);
      u_ctrl.set_enable(1'b1);
      u_ctrl.issue(dibc_pkg::CMD_ACT, 2'h0, 1'b0);
      u_ctrl.idle(XSR + 6);
      check("act before exit delay", st(0), dibc_pkg::BK_IDLE);
      u_ctrl.issue(dibc_pkg::CMD_ACT, 2'h0, 1'b0);
      wait_state("activating", 0, dibc_pkg::BK_ACTV);
      wait_state("row active", 0, dibc_pkg::BK_ROW);
   endtask
   task automatic t_deselect();
      u_ctrl.issue(dibc_pkg::CMD_NOP, 2'h0, 1'b0);
      u_ctrl.idle(20);
      check("after nop", st(0), dibc_pkg::BK_ROW);
      check("nop violation", violation_ff, 1'b0);
   endtask
   // legal mix of other-bank traffic leaves the sticky flag clear
   task automatic t_legal();
      u_ctrl.issue(dibc_pkg::CMD_ACT, 2'h1, 1'b0);
      wait_state("bank1 active", 1, dibc_pkg::BK_ROW);
      u_ctrl.issue(dibc_pkg::CMD_RD, 2'h0, 1'b0);
      u_ctrl.issue(dibc_pkg::CMD_RD, 2'h1, 1'b0);
      u_ctrl.idle(8);
      u_ctrl.issue(dibc_pkg::CMD_WR, 2'h0, 1'b0);
      u_ctrl.issue(dibc_pkg::CMD_RD, 2'h1, 1'b0);
      u_ctrl.idle(8);
      u_ctrl.issue(dibc_pkg::CMD_WR, 2'h1, 1'b1);
      u_ctrl.idle(1);
      u_ctrl.issue(dibc_pkg::CMD_ACT, 2'h2, 1'b0);
      wait_state("write ap closing", 1, dibc_pkg::BK_PRE);
      u_ctrl.issue(dibc_pkg::CMD_RD, 2'h0, 1'b0);
      wait_state("write ap closed", 1, dibc_pkg::BK_IDLE);
      check("legal mix violation", violation_ff, 1'b0);
   endtask
   task automatic t_space();
      cases = '{
         '{dibc_pkg::CMD_RD, 0, dibc_pkg::CMD_WR, 1, 1, 1},
         '{dibc_pkg::CMD_RD, 1, dibc_pkg::CMD_WR, 1, CL + HB, 0},
         '{dibc_pkg::CMD_RD, 1, dibc_pkg::CMD_WR, 1, CL + HB - 1, 1},
         '{dibc_pkg::CMD_RD, 1, dibc_pkg::CMD_RD, 1, HB, 0},
         '{dibc_pkg::CMD_RD, 1, dibc_pkg::CMD_RD, 1, HB - 1, 1},
         '{dibc_pkg::CMD_WR, 1, dibc_pkg::CMD_RD, 1, 1 + HB + WTR, 0},
         '{dibc_pkg::CMD_WR, 1, dibc_pkg::CMD_RD, 1, HB + WTR, 1},
         '{dibc_pkg::CMD_WR, 1, dibc_pkg::CMD_WR, 1, HB, 0},
         '{dibc_pkg::CMD_WR, 1, dibc_pkg::CMD_WR, 1, HB - 1, 1},
         '{dibc_pkg::CMD_WR, 1, dibc_pkg::CMD_PRE, 1, 1, 0},
         '{dibc_pkg::CMD_RD, 1, dibc_pkg::CMD_ACT, 2, 1, 0},
         '{dibc_pkg::CMD_RD, 0, dibc_pkg::CMD_BST, 1, 1, 0},
         '{dibc_pkg::CMD_PRE, 0, dibc_pkg::CMD_BST, 0, 1, 1},
         '{dibc_pkg::CMD_RD, 1, dibc_pkg::CMD_REF, 0, 1, 1},
         '{dibc_pkg::CMD_RD, 1, dibc_pkg::CMD_MRS, 0, 1, 1}};
      foreach (cases[i]) begin
         do_reset();
         u_ctrl.issue(dibc_pkg::CMD_ACT, 2'h0, 1'b0);
         u_ctrl.issue(dibc_pkg::CMD_ACT, 2'h1, 1'b0);
         u_ctrl.idle(RCD + 2);
         u_ctrl.issue(cases[i].c1, 2'h0, cases[i].a1);
         if (cases[i].gap > 1) begin
            u_ctrl.idle(cases[i].gap - 1);
         end
         u_ctrl.issue(cases[i].c2, cases[i].b2, 1'b0);
         u_ctrl.idle(6);
         check($sformatf("spacing case %0d", i), violation_ff,
               cases[i].viol);
      end
   endtask
   task automatic t_refresh();
      do_reset();
      u_ctrl.issue(dibc_pkg::CMD_REF, 2'h0, 1'b0);
      wait_state("refreshing", 3, dibc_pkg::BK_PRE);
      wait_state("refresh done", 3, dibc_pkg::BK_IDLE);
      u_ctrl.issue(dibc_pkg::CMD_MRS, 2'h0, 1'b0);
      u_ctrl.idle(6);
      u_ctrl.issue(dibc_pkg::CMD_ACT, 2'h0, 1'b0);
      u_ctrl.issue(dibc_pkg::CMD_ACT, 2'h3, 1'b0);
      u_ctrl.idle(RCD + 2);
      u_ctrl.issue(dibc_pkg::CMD_PRE, 2'h1, 1'b1);
      wait_state("all closed b0", 0, dibc_pkg::BK_IDLE);
      check("all closed b3", st(3), dibc_pkg::BK_IDLE);
      check("idle refresh violation", violation_ff, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #400000;
      mismatches++;
      finish_test();
   end
   initial begin
      t_reset_values();
      t_enable_gate();
      t_deselect();
      t_legal();
      t_space();
      t_refresh();
      finish_test();
   end
endmodule

// *** src/dibc_pkg.sv ***
// constants and types for the inter-bank command tracker
// assumes the link clock is the memory command clock, one command per edge
package dibc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // timing figures in their own units, then cycle counts
   localparam int LINK_PERIOD_PS = 5000;
   localparam int RCD_NS = 15;
   localparam int RP_NS = 15;
   localparam int WR_NS = 15;
   localparam int RFC_NS = 70;
   localparam int MRD_NS = 10;
   localparam int XSR_NS = 200;
   localparam int WTR_CK = 1;
   localparam int BURST_LEN = 4;
   localparam int CAS_LAT_UP = 3;

   // least times round up to whole cycles
   localparam int RCD_CK = (RCD_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int RP_CK = (RP_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int WR_CK = (WR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int RFC_CK = (RFC_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int MRD_CK = (MRD_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int XSR_CK = (XSR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;

   ////////////////////////////////////////////////////////////////////////
   localparam int NUM_BANKS = 4;
   localparam int CNT_W = 8;
   localparam int ST_W = 3;
   localparam int SNAP_W = NUM_BANKS * ST_W + 1;

   // gray codes along open, access, close
   typedef enum logic [2:0] {
      BK_IDLE = 3'h0,
      BK_ACTV = 3'h1,
      BK_ROW = 3'h3,
      BK_RD = 3'h2,
      BK_WR = 3'h6,
      BK_RDAP = 3'h7,
      BK_WRAP = 3'h5,
      BK_PRE = 3'h4
   } dibc_bank_t;

   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACT = 3'h1,
      CMD_RD = 3'h2,
      CMD_WR = 3'h3,
      CMD_PRE = 3'h4,
      CMD_REF = 3'h5,
      CMD_MRS = 3'h6,
      CMD_BST = 3'h7
   } dibc_cmd_t;

endpackage

// *** src/dibc_tracker.sv ***
// bank state tracker and inter-bank legality monitor of the memory device
// assumes command pins are launched on the link clock; rst resets both sides
`timescale 1ns/1ps

module dibc_tracker #(
   parameter int BURST_LEN = dibc_pkg::BURST_LEN,
   parameter int CAS_LAT_UP = dibc_pkg::CAS_LAT_UP,
   parameter int RCD_CK = dibc_pkg::RCD_CK,
   parameter int RP_CK = dibc_pkg::RP_CK,
   parameter int WR_CK = dibc_pkg::WR_CK,
   parameter int WTR_CK = dibc_pkg::WTR_CK,
   parameter int RFC_CK = dibc_pkg::RFC_CK,
   parameter int MRD_CK = dibc_pkg::MRD_CK,
   parameter int XSR_CK = dibc_pkg::XSR_CK
) (
   // core side
   input wire logic clock,
   input wire logic rst,
   output logic [dibc_pkg::NUM_BANKS*dibc_pkg::ST_W-1:0] bankState_ff,
   output logic violation_ff,
   output logic update_ff,
   // command pins, on the link clock
   input wire logic linkClk,
   input wire logic clkEnable,
   input wire logic chipSelN,
   input wire logic rowStrobeN,
   input wire logic colStrobeN,
   input wire logic writeEnN,
   input wire logic [1:0] bankAddr,
   input wire logic autoPre
);
   localparam int NB = dibc_pkg::NUM_BANKS;
   localparam int CW = dibc_pkg::CNT_W;
   localparam int HB = BURST_LEN / 2;
   localparam int WRAP_ACC = 1 + HB + WR_CK;
   localparam int WRAP_TO_RD = 1 + HB + WTR_CK;
   localparam int RD_DATA = CAS_LAT_UP + HB;
   localparam int A_RCD = RCD_CK;
   localparam int A_HB = HB;
   localparam int A_WRAP = WRAP_ACC;
   localparam int A_RP = RP_CK;

   if (BURST_LEN != 2 && BURST_LEN != 4 && BURST_LEN != 8)
      $error("burst length must be 2, 4 or 8");
   if (RCD_CK < 1 || RP_CK < 1 || WR_CK < 1 || RFC_CK < 1 || MRD_CK < 1 ||
       XSR_CK < 1 || WRAP_ACC > 250 || RFC_CK > 250 || XSR_CK > 250 ||
       RD_DATA > 250 || WRAP_TO_RD > 250)
      $error("timing counts out of range");

   // pin command decode, strobes given row, column, write
   function automatic dibc_pkg::dibc_cmd_t decode(input logic r,
                                                  input logic c,
                                                  input logic w);
      case ({r, c, w})
         3'h3: decode = dibc_pkg::CMD_ACT;
         3'h5: decode = dibc_pkg::CMD_RD;
         3'h4: decode = dibc_pkg::CMD_WR;
         3'h2: decode = dibc_pkg::CMD_PRE;
         3'h1: decode = dibc_pkg::CMD_REF;
         3'h0: decode = dibc_pkg::CMD_MRS;
         3'h6: decode = dibc_pkg::CMD_BST;
         default: decode = dibc_pkg::CMD_NOP;
      endcase
   endfunction

   function automatic logic [CW-1:0] sat(input logic [CW-1:0] v);
      sat = (v == {CW{1'b1}}) ? v : v + 8'h01;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // link domain: pin capture
   logic ckeQ_ff, ckePrev_ff, csNQ_ff, rasQ_ff, casQ_ff, weQ_ff, apQ_ff;
   logic [1:0] bankQ_ff;
   always_ff @(posedge linkClk or posedge rst) begin
      if (rst) begin
         ckeQ_ff <= 1'b0;
         ckePrev_ff <= 1'b0;
         csNQ_ff <= 1'b1;
         rasQ_ff <= 1'b1;
         casQ_ff <= 1'b1;
         weQ_ff <= 1'b1;
         apQ_ff <= 1'b0;
         bankQ_ff <= 2'h0;
      end else begin
         ckeQ_ff <= clkEnable;
         ckePrev_ff <= ckeQ_ff;
         csNQ_ff <= chipSelN;
         rasQ_ff <= rowStrobeN;
         casQ_ff <= colStrobeN;
         weQ_ff <= writeEnN;
         apQ_ff <= autoPre;
         bankQ_ff <= bankAddr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link domain: bank states and spacing counters
   dibc_pkg::dibc_bank_t bankSt_ff [NB];
   dibc_pkg::dibc_bank_t nxt_bankSt [NB];
   logic [CW-1:0] bankCnt_ff [NB];
   logic [CW-1:0] nxt_bankCnt [NB];
   logic [CW-1:0] xsrCnt_ff, nxt_xsrCnt, rdData_ff, nxt_rdData;
   logic [CW-1:0] sinceWrAp_ff, nxt_sinceWrAp, sinceRdAp_ff, nxt_sinceRdAp;
   logic [1:0] lastRd_ff, nxt_lastRd, wrApBank_ff, nxt_wrApBank;
   logic [1:0] rdApBank_ff, nxt_rdApBank;
   logic viol_ff, nxt_viol;
   logic cmdValid, allIdle, otherRd;
   dibc_pkg::dibc_cmd_t cmd;

   always_comb begin
      cmdValid = ckePrev_ff && ckeQ_ff && xsrCnt_ff == 8'h00 && !csNQ_ff;
      cmd = cmdValid ? decode(rasQ_ff, casQ_ff, weQ_ff) : dibc_pkg::CMD_NOP;
      allIdle = 1'b1;
      otherRd = 1'b0;
      for (int b = 0; b < NB; b++) begin
         if (bankSt_ff[b] != dibc_pkg::BK_IDLE)
            allIdle = 1'b0;
         if (bankSt_ff[b] == dibc_pkg::BK_RD && b != int'(bankQ_ff))
            otherRd = 1'b1;
      end
      nxt_xsrCnt = (!ckePrev_ff && ckeQ_ff) ? CW'(XSR_CK) :
                   (xsrCnt_ff != 8'h00) ? xsrCnt_ff - 8'h01 : xsrCnt_ff;
      nxt_rdData = (rdData_ff != 8'h00) ? rdData_ff - 8'h01 : rdData_ff;
      nxt_sinceWrAp = sat(sinceWrAp_ff);
      nxt_sinceRdAp = sat(sinceRdAp_ff);
      nxt_lastRd = lastRd_ff;
      nxt_wrApBank = wrApBank_ff;
      nxt_rdApBank = rdApBank_ff;
      nxt_viol = viol_ff;
      for (int b = 0; b < NB; b++) begin
         nxt_bankSt[b] = bankSt_ff[b];
         nxt_bankCnt[b] = bankCnt_ff[b];
         if (bankCnt_ff[b] != 8'h00)
            nxt_bankCnt[b] = bankCnt_ff[b] - 8'h01;
         if (bankCnt_ff[b] == 8'h01) begin
            case (bankSt_ff[b])
               dibc_pkg::BK_ACTV, dibc_pkg::BK_RD, dibc_pkg::BK_WR:
                  nxt_bankSt[b] = dibc_pkg::BK_ROW;
               // precharge period follows the access period
               dibc_pkg::BK_RDAP, dibc_pkg::BK_WRAP: begin
                  nxt_bankSt[b] = dibc_pkg::BK_PRE;
                  nxt_bankCnt[b] = CW'(RP_CK);
               end
               dibc_pkg::BK_PRE: nxt_bankSt[b] = dibc_pkg::BK_IDLE;
               default: nxt_bankSt[b] = bankSt_ff[b];
            endcase
         end
      end
      // commands to one bank leave the others running
      case (cmd)
         dibc_pkg::CMD_ACT: begin
            nxt_bankSt[bankQ_ff] = dibc_pkg::BK_ACTV;
            nxt_bankCnt[bankQ_ff] = CW'(RCD_CK);
         end
         dibc_pkg::CMD_RD: begin
            if ((sinceWrAp_ff < CW'(WRAP_TO_RD) && wrApBank_ff != bankQ_ff) ||
                (sinceRdAp_ff < CW'(HB) && rdApBank_ff != bankQ_ff))
               nxt_viol = 1'b1;
            // read AP: earliest precharge is half a burst on
            nxt_bankSt[bankQ_ff] = apQ_ff ? dibc_pkg::BK_RDAP : dibc_pkg::BK_RD;
            nxt_bankCnt[bankQ_ff] = CW'(HB);
            nxt_lastRd = bankQ_ff;
            // counts hold cycles already gone by the next command edge
            nxt_rdData = CW'(RD_DATA - 1);
            if (apQ_ff) begin
               nxt_sinceRdAp = 8'h01;
               nxt_rdApBank = bankQ_ff;
            end
         end
         dibc_pkg::CMD_WR: begin
            if (otherRd || rdData_ff != 8'h00 ||
                (sinceWrAp_ff < CW'(HB) && wrApBank_ff != bankQ_ff))
               nxt_viol = 1'b1;
            // write AP closes after recovery
            nxt_bankSt[bankQ_ff] = apQ_ff ? dibc_pkg::BK_WRAP : dibc_pkg::BK_WR;
            nxt_bankCnt[bankQ_ff] = apQ_ff ? CW'(WRAP_ACC) : CW'(1 + HB);
            if (apQ_ff) begin
               nxt_sinceWrAp = 8'h01;
               nxt_wrApBank = bankQ_ff;
            end
         end
         dibc_pkg::CMD_PRE: begin
            for (int b = 0; b < NB; b++) begin
               if (apQ_ff || b == int'(bankQ_ff)) begin
                  nxt_bankSt[b] = dibc_pkg::BK_PRE;
                  nxt_bankCnt[b] = CW'(RP_CK);
               end
            end
         end
         dibc_pkg::CMD_REF, dibc_pkg::CMD_MRS: begin
            if (!allIdle)
               nxt_viol = 1'b1;
            // busy window shown as all banks closing
            for (int b = 0; b < NB; b++) begin
               nxt_bankSt[b] = dibc_pkg::BK_PRE;
               nxt_bankCnt[b] = (cmd == dibc_pkg::CMD_REF) ?
                                CW'(RFC_CK) : CW'(MRD_CK);
            end
         end
         dibc_pkg::CMD_BST: begin
            if (bankSt_ff[lastRd_ff] == dibc_pkg::BK_RD) begin
               nxt_bankSt[lastRd_ff] = dibc_pkg::BK_ROW;
               nxt_bankCnt[lastRd_ff] = 8'h00;
            end else begin
               nxt_viol = 1'b1;
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge linkClk or posedge rst) begin
      if (rst) begin
         for (int b = 0; b < NB; b++) begin
            bankSt_ff[b] <= dibc_pkg::BK_IDLE;
            bankCnt_ff[b] <= 8'h00;
         end
         xsrCnt_ff <= 8'h00;
         rdData_ff <= 8'h00;
         sinceWrAp_ff <= 8'hFF;
         sinceRdAp_ff <= 8'hFF;
         lastRd_ff <= 2'h0;
         wrApBank_ff <= 2'h0;
         rdApBank_ff <= 2'h0;
         viol_ff <= 1'b0;
      end else begin
         for (int b = 0; b < NB; b++) begin
            bankSt_ff[b] <= nxt_bankSt[b];
            bankCnt_ff[b] <= nxt_bankCnt[b];
         end
         xsrCnt_ff <= nxt_xsrCnt;
         rdData_ff <= nxt_rdData;
         sinceWrAp_ff <= nxt_sinceWrAp;
         sinceRdAp_ff <= nxt_sinceRdAp;
         lastRd_ff <= nxt_lastRd;
         wrApBank_ff <= nxt_wrApBank;
         rdApBank_ff <= nxt_rdApBank;
         viol_ff <= nxt_viol;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // crossing: toggle handshake carries a held snapshot to the core
   // a snapshot is only re-taken after the core acknowledged the last one,
   // so the core sees coarse samples, never torn words
   logic reqTgl_ff, nxt_reqTgl, ackS1_ff, ackS2_ff;
   logic [dibc_pkg::SNAP_W-1:0] snap_ff, nxt_snap;
   always_comb begin
      nxt_reqTgl = reqTgl_ff;
      nxt_snap = snap_ff;
      if (reqTgl_ff == ackS2_ff) begin
         nxt_reqTgl = !reqTgl_ff;
         nxt_snap = {nxt_viol, nxt_bankSt[3], nxt_bankSt[2],
                     nxt_bankSt[1], nxt_bankSt[0]};
      end
   end

   logic ackTgl_ff, nxt_ackTgl;
   always_ff @(posedge linkClk or posedge rst) begin
      if (rst) begin
         reqTgl_ff <= 1'b0;
         snap_ff <= '0;
         ackS1_ff <= 1'b0;
         ackS2_ff <= 1'b0;
      end else begin
         reqTgl_ff <= nxt_reqTgl;
         snap_ff <= nxt_snap;
         ackS1_ff <= ackTgl_ff;
         ackS2_ff <= ackS1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // core domain
   logic reqS1_ff, reqS2_ff, nxt_update, nxt_violOut;
   logic [dibc_pkg::NUM_BANKS*dibc_pkg::ST_W-1:0] nxt_bankState;
   always_comb begin
      nxt_ackTgl = ackTgl_ff;
      nxt_update = 1'b0;
      nxt_bankState = bankState_ff;
      nxt_violOut = violation_ff;
      if (reqS2_ff != ackTgl_ff) begin
         nxt_ackTgl = reqS2_ff;
         nxt_update = 1'b1;
         nxt_bankState = snap_ff[dibc_pkg::SNAP_W-2:0];
         nxt_violOut = snap_ff[dibc_pkg::SNAP_W-1];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reqS1_ff <= 1'b0;
         reqS2_ff <= 1'b0;
         ackTgl_ff <= 1'b0;
         update_ff <= 1'b0;
         bankState_ff <= '0;
         violation_ff <= 1'b0;
      end else begin
         reqS1_ff <= reqTgl_ff;
         reqS2_ff <= reqS1_ff;
         ackTgl_ff <= nxt_ackTgl;
         update_ff <= nxt_update;
         bankState_ff <= nxt_bankState;
         violation_ff <= nxt_violOut;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_enable_gate: assert property (@(posedge linkClk) disable iff (rst)
      !ckePrev_ff |-> !cmdValid) else $error("command taken with enable low");
   a_deselect_hold: assert property (@(posedge linkClk) disable iff (rst)
      (csNQ_ff && bankSt_ff[0] == dibc_pkg::BK_ROW)
      |=> bankSt_ff[0] == dibc_pkg::BK_ROW) else $error("deselect moved bank");
   a_nop_hold: assert property (@(posedge linkClk) disable iff (rst)
      (cmdValid && rasQ_ff && casQ_ff && weQ_ff &&
       bankSt_ff[1] == dibc_pkg::BK_IDLE)
      |=> bankSt_ff[1] == dibc_pkg::BK_IDLE) else $error("nop moved bank");
   a_act_opens: assert property (@(posedge linkClk) disable iff (rst)
      cmd == dibc_pkg::CMD_ACT |=> bankSt_ff[$past(bankQ_ff)] ==
      dibc_pkg::BK_ACTV) else $error("activate not taken");
   a_rcd_done: assert property (@(posedge linkClk) disable iff (rst)
      ($rose(bankSt_ff[2] == dibc_pkg::BK_ACTV) && bankCnt_ff[2] == 8'(A_RCD))
      |-> ##A_RCD (bankSt_ff[2] != dibc_pkg::BK_ACTV))
      else $error("row delay length wrong");
   a_rdap_split: assert property (@(posedge linkClk) disable iff (rst)
      ($rose(bankSt_ff[0] == dibc_pkg::BK_RDAP) && !$past(cmd == dibc_pkg::CMD_PRE))
      |-> ##A_HB (bankSt_ff[0] != dibc_pkg::BK_RDAP))
      else $error("read auto-precharge access length wrong");
   a_wrap_split: assert property (@(posedge linkClk) disable iff (rst)
      (cmd == dibc_pkg::CMD_WR && apQ_ff && bankQ_ff == 2'h0)
      |=> bankCnt_ff[0] == 8'(A_WRAP)) else $error("write recovery wrong");
   a_pre_length: assert property (@(posedge linkClk) disable iff (rst)
      (bankSt_ff[1] == dibc_pkg::BK_WRAP && bankCnt_ff[1] == 8'h01)
      |=> bankSt_ff[1] == dibc_pkg::BK_PRE && bankCnt_ff[1] == 8'(A_RP))
      else $error("precharge period not started");
   a_bst_last: assert property (@(posedge linkClk) disable iff (rst)
      (cmd == dibc_pkg::CMD_BST && bankSt_ff[lastRd_ff] == dibc_pkg::BK_RD)
      |=> bankSt_ff[$past(lastRd_ff)] == dibc_pkg::BK_ROW)
      else $error("terminate missed latest read");
   a_ref_idle: assert property (@(posedge linkClk) disable iff (rst)
      (cmd == dibc_pkg::CMD_REF && !allIdle) |=> viol_ff)
      else $error("refresh with open bank not flagged");
endmodule
